// *** design/adc_sequencer_control.sv ***
`timescale 1ns/10ps
`default_nettype none

module adc_sequencer_control (
	input  wire logic                 clk,            // system clock
	input  wire logic                 reset,          // async reset, active high
	input  wire logic                 clk_en,         // freezes all state when low
	input  wire logic                 standby,        // module standby, aborts conversion, clears control, trigger, flag and result registers
	input  wire adc_seq_pkg::cpu_req_s cpu,           // cpu byte access
	output logic [7:0]                rdata,          // read data, valid cycle after rd
	output logic                      done_irq,       // conversion-end interrupt
	input  wire logic                 ext_trig_n,     // external trigger, falling edge
	input  wire logic                 timer_match,    // timer compare match pulse
	input  wire logic                 timer_trig_sel, // timer owns the trigger when 1
	input  wire logic [9:0]           conv_result,    // analog core result at conversion end
	output logic [2:0]                analog_sel,     // selected analog input
	output logic                      sample_en,      // sample-and-hold window
	output logic                      busy            // conversion in progress
);

	localparam int SLOW_MIN = 131;
	localparam int SLOW_MAX = 134;
	localparam int FAST_MIN = 69;
	localparam int FAST_MAX = 70;

	adc_seq_pkg::conv_state_e state_reg;

	logic       flag_reg;
	logic       ie_reg;
	logic       go_reg;
	logic       scan_reg;
	logic       speed_reg;
	logic [2:0] chan_reg;
	logic       trig_en_reg;
	logic       spare_reg;
	logic       flag_arm_reg;
	logic [1:0] ch_idx_reg;
	logic       trig_prev_reg;
	logic [1:0] presc_reg;
	logic [7:0] low_byte_latch;
	logic [9:0] result_reg [4];

	logic       wr_ctrl;
	logic       wr_trig;
	logic       rd_ctrl;
	logic       trig_fire;
	logic       start_fresh;
	logic       start_next;
	logic       tmr_start;
	logic       tmr_done;
	logic       tmr_smp;
	logic       abort;
	logic       accept;
	logic       last_ch;
	logic [1:0] res_idx;
	logic [7:0] td_sel;
	logic [7:0] tail_sel;
	logic [7:0] spl_sel;

	assign wr_ctrl = cpu.wr && (cpu.addr == adc_seq_pkg::OFF_CTRL_STATUS);
	assign wr_trig = cpu.wr && (cpu.addr == adc_seq_pkg::OFF_TRIG_CTRL);
	assign rd_ctrl = cpu.rd && (cpu.addr == adc_seq_pkg::OFF_CTRL_STATUS);

	// pin edge only when the timer does not own the trigger
	assign trig_fire = trig_en_reg && (timer_trig_sel ? timer_match : (trig_prev_reg && !ext_trig_n));

	assign start_fresh = go_reg && (state_reg == adc_seq_pkg::ST_IDLE) && !standby;
	assign abort       = (state_reg == adc_seq_pkg::ST_CONV) && (!go_reg || standby);
	assign accept      = tmr_done && go_reg && !standby && (state_reg == adc_seq_pkg::ST_CONV);
	assign last_ch     = !scan_reg || (ch_idx_reg == chan_reg[1:0]);
	assign start_next  = accept && scan_reg;
	assign tmr_start   = start_fresh || start_next;
	assign res_idx     = scan_reg ? ch_idx_reg : chan_reg[1:0];

	// first conversion delay depends on prescaler phase at the write
	always_comb begin
		if (speed_reg) begin
			tail_sel = adc_seq_pkg::TAIL_FAST;
			spl_sel  = adc_seq_pkg::SPL_FAST;
			td_sel   = start_next ? adc_seq_pkg::TD_SCAN_FAST : {4'h0, adc_seq_pkg::TD_FAST_MIN + {3'h0, presc_reg[0]}};
		end else begin
			tail_sel = adc_seq_pkg::TAIL_SLOW;
			spl_sel  = adc_seq_pkg::SPL_SLOW;
			td_sel   = start_next ? adc_seq_pkg::TD_SCAN_SLOW : {4'h0, adc_seq_pkg::TD_SLOW_MIN + {2'h0, presc_reg}};
		end
	end

	adc_conv_timer #(
		.CW(8)
	) u_timer (
		.clk   (clk),
		.reset (reset),
		.clk_en(clk_en),
		.clear (abort),
		.start (tmr_start),
		.td    (td_sel),
		.tail  (tail_sel),
		.spl   (spl_sel),
		.smp   (tmr_smp),
		.done  (tmr_done)
	);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			presc_reg     <= 2'h0;
			trig_prev_reg <= 1'b1;
		end else if (clk_en) begin
			presc_reg     <= presc_reg + 2'h1;
			trig_prev_reg <= ext_trig_n;
		end
	end

	// mode fields: every control write rewrites them, even while go is set
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ie_reg    <= adc_seq_pkg::CTRL_RESET[adc_seq_pkg::CTRL_IE_BIT];
			scan_reg  <= adc_seq_pkg::CTRL_RESET[adc_seq_pkg::CTRL_SCAN_BIT];
			speed_reg <= adc_seq_pkg::CTRL_RESET[adc_seq_pkg::CTRL_SPEED_BIT];
			chan_reg  <= adc_seq_pkg::CTRL_RESET[adc_seq_pkg::CTRL_CHAN_MSB:0];
		end else if (clk_en) begin
			if (standby) begin
				ie_reg    <= adc_seq_pkg::CTRL_RESET[adc_seq_pkg::CTRL_IE_BIT];
				scan_reg  <= adc_seq_pkg::CTRL_RESET[adc_seq_pkg::CTRL_SCAN_BIT];
				speed_reg <= adc_seq_pkg::CTRL_RESET[adc_seq_pkg::CTRL_SPEED_BIT];
				chan_reg  <= adc_seq_pkg::CTRL_RESET[adc_seq_pkg::CTRL_CHAN_MSB:0];
			end else if (wr_ctrl) begin
				ie_reg    <= cpu.wdata[adc_seq_pkg::CTRL_IE_BIT];
				scan_reg  <= cpu.wdata[adc_seq_pkg::CTRL_SCAN_BIT];
				speed_reg <= cpu.wdata[adc_seq_pkg::CTRL_SPEED_BIT];
				chan_reg  <= cpu.wdata[adc_seq_pkg::CTRL_CHAN_MSB:0];
			end
		end
	end

	// go: a trigger wins over a write, a write over the self-clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			go_reg <= 1'b0;
		end else if (clk_en) begin
			if (standby) begin
				go_reg <= 1'b0;
			end else if (trig_fire) begin
				go_reg <= 1'b1;
			end else if (wr_ctrl) begin
				go_reg <= cpu.wdata[adc_seq_pkg::CTRL_GO_BIT];
			end else if (accept && !scan_reg) begin
				go_reg <= 1'b0;
			end
		end
	end

	// done flag: set wins over the read-then-write clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			flag_reg     <= 1'b0;
			flag_arm_reg <= 1'b0;
		end else if (clk_en) begin
			if (standby) begin
				flag_reg     <= 1'b0;
				flag_arm_reg <= 1'b0;
			end else begin
				if (accept && last_ch) begin
					flag_reg <= 1'b1;
				end else if (wr_ctrl && flag_arm_reg && !cpu.wdata[adc_seq_pkg::CTRL_FLAG_BIT]) begin
					flag_reg <= 1'b0;
				end
				if (rd_ctrl && flag_reg) begin
					flag_arm_reg <= 1'b1;
				end else if (wr_ctrl || !flag_reg) begin
					flag_arm_reg <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg  <= adc_seq_pkg::ST_IDLE;
			ch_idx_reg <= 2'h0;
		end else if (clk_en) begin
			unique case (state_reg)
				adc_seq_pkg::ST_IDLE: begin
					if (start_fresh) begin
						state_reg  <= adc_seq_pkg::ST_CONV;
						ch_idx_reg <= 2'h0;
					end
				end
				adc_seq_pkg::ST_CONV: begin
					if (abort) begin
						state_reg <= adc_seq_pkg::ST_IDLE;
					end else if (accept) begin
						if (!scan_reg) begin
							state_reg <= adc_seq_pkg::ST_IDLE;
						end
						ch_idx_reg <= last_ch ? 2'h0 : ch_idx_reg + 2'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			trig_en_reg <= adc_seq_pkg::TRIG_RESET[adc_seq_pkg::TRIG_EN_BIT];
			spare_reg   <= adc_seq_pkg::TRIG_RESET[adc_seq_pkg::TRIG_SPARE_BIT];
		end else if (clk_en) begin
			if (standby) begin
				trig_en_reg <= adc_seq_pkg::TRIG_RESET[adc_seq_pkg::TRIG_EN_BIT];
				spare_reg   <= adc_seq_pkg::TRIG_RESET[adc_seq_pkg::TRIG_SPARE_BIT];
			end else if (wr_trig) begin
				trig_en_reg <= cpu.wdata[adc_seq_pkg::TRIG_EN_BIT];
				spare_reg   <= cpu.wdata[adc_seq_pkg::TRIG_SPARE_BIT];
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < 4; i++) begin
				result_reg[i] <= adc_seq_pkg::RESULT_RESET;
			end
		end else if (clk_en) begin
			if (standby) begin
				for (int i = 0; i < 4; i++) begin
					result_reg[i] <= adc_seq_pkg::RESULT_RESET;
				end
			end else if (accept) begin
				result_reg[res_idx] <= conv_result;
			end
		end
	end

	// cpu read port and lower-byte latch
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata          <= 8'h00;
			low_byte_latch <= 8'h00;
		end else if (clk_en) begin
			if (cpu.rd) begin
				if (cpu.addr[3] == adc_seq_pkg::OFF_RES_BASE[3]) begin
					if (!cpu.addr[0]) begin
						rdata          <= result_reg[cpu.addr[2:1]][9:2];
						low_byte_latch <= {result_reg[cpu.addr[2:1]][1:0], 6'h00};
					end else begin
						rdata <= low_byte_latch;
					end
				end else if (cpu.addr == adc_seq_pkg::OFF_CTRL_STATUS) begin
					rdata <= {flag_reg, ie_reg, go_reg, scan_reg, speed_reg, chan_reg};
				end else if (cpu.addr == adc_seq_pkg::OFF_TRIG_CTRL) begin
					rdata <= {trig_en_reg, adc_seq_pkg::TRIG_FIXED_ONES, spare_reg};
				end else begin
					rdata <= 8'h00;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			done_irq   <= 1'b0;
			analog_sel <= 3'h0;
			sample_en  <= 1'b0;
			busy       <= 1'b0;
		end else if (clk_en) begin
			done_irq   <= flag_reg && ie_reg;
			analog_sel <= scan_reg ? {chan_reg[2], ch_idx_reg} : chan_reg;
			sample_en  <= tmr_smp;
			busy       <= (state_reg == adc_seq_pkg::ST_CONV) && !abort;
		end
	end

	// age of the running conversion, so an abandoned one cannot upset the timing checks
	logic [7:0] conv_age_reg;
	logic       conv_first_reg;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			conv_age_reg   <= 8'h00;
			conv_first_reg <= 1'b0;
		end else if (clk_en) begin
			if (tmr_start) begin
				conv_age_reg   <= 8'h01;
				conv_first_reg <= start_fresh;
			end else if (conv_age_reg != 8'hff) begin
				conv_age_reg <= conv_age_reg + 8'h01;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset || !clk_en || standby);

	sequence s_slow_end;
		(int'(conv_age_reg) >= SLOW_MIN) && (int'(conv_age_reg) <= SLOW_MAX);
	endsequence
	sequence s_fast_end;
		(int'(conv_age_reg) >= FAST_MIN) && (int'(conv_age_reg) <= FAST_MAX);
	endsequence

	property p_single_end;
		accept && !scan_reg && !wr_ctrl && !trig_fire |=> !go_reg && flag_reg && state_reg == adc_seq_pkg::ST_IDLE;
	endproperty
	a_single_end: assert property (p_single_end) else $error("single conversion end not taken");

	property p_irq;
		(flag_reg && ie_reg |=> done_irq) and (!ie_reg |=> !done_irq);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt does not follow flag and enable");

	property p_flag_clear;
		$fell(flag_reg) |-> ($past(flag_arm_reg) && $past(wr_ctrl)) || $past(standby);
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("done flag cleared without read then write");

	property p_trig_block;
		!trig_en_reg && !wr_ctrl && !go_reg |=> !go_reg;
	endproperty
	a_trig_block: assert property (p_trig_block) else $error("go set while triggers blocked");

	property p_trig_read;
		cpu.rd && cpu.addr == adc_seq_pkg::OFF_TRIG_CTRL |=> rdata[6:1] == 6'h3f;
	endproperty
	a_trig_read: assert property (p_trig_read) else $error("reserved trigger bits not read as one");

	property p_latch;
		cpu.rd && cpu.addr == 4'h0 && !accept |=> low_byte_latch == {result_reg[0][1:0], 6'h00};
	endproperty
	a_latch: assert property (p_latch) else $error("lower byte latch wrong");

	property p_latch_read;
		cpu.rd && !cpu.addr[3] && cpu.addr[0] |=> rdata == $past(low_byte_latch);
	endproperty
	a_latch_read: assert property (p_latch_read) else $error("lower byte read not from latch");

	property p_slow_time;
		accept && conv_first_reg && !speed_reg |-> s_slow_end;
	endproperty
	a_slow_time: assert property (p_slow_time) else $error("slow conversion length out of range");

	property p_fast_time;
		accept && conv_first_reg && speed_reg |-> s_fast_end;
	endproperty
	a_fast_time: assert property (p_fast_time) else $error("fast conversion length out of range");

	property p_scan_slow;
		accept && !conv_first_reg && !speed_reg |-> conv_age_reg == adc_seq_pkg::SCAN_LEN_SLOW;
	endproperty
	a_scan_slow: assert property (p_scan_slow) else $error("scan conversion not 128 states");

	property p_scan_wrap;
		accept && scan_reg && last_ch |=> ch_idx_reg == 2'h0 && flag_reg;
	endproperty
	a_scan_wrap: assert property (p_scan_wrap) else $error("scan pass end not handled");

	property p_abort;
		abort |=> state_reg == adc_seq_pkg::ST_IDLE && $stable(result_reg[0]) && $stable(result_reg[3]);
	endproperty
	a_abort: assert property (p_abort) else $error("abandoned conversion left effects");

endmodule
`default_nettype wire

// *** pkg/adc_seq_pkg.sv ***
package adc_seq_pkg;

	// byte offsets on the 8-bit cpu bus
	localparam logic [3:0] OFF_RES_BASE    = 4'h0;
	localparam logic [3:0] OFF_CTRL_STATUS = 4'h8;
	localparam logic [3:0] OFF_TRIG_CTRL   = 4'h9;

	// ctrl_status_reg field positions
	localparam int CTRL_FLAG_BIT  = 7;
	localparam int CTRL_IE_BIT    = 6;
	localparam int CTRL_GO_BIT    = 5;
	localparam int CTRL_SCAN_BIT  = 4;
	localparam int CTRL_SPEED_BIT = 3;
	localparam int CTRL_CHAN_MSB  = 2;

	// trig_ctrl_reg field positions
	localparam int TRIG_EN_BIT    = 7;
	localparam int TRIG_SPARE_BIT = 0;

	// reset values
	localparam logic [7:0] CTRL_RESET      = 8'h00;
	localparam logic [7:0] TRIG_RESET      = 8'h7f;
	localparam logic [5:0] TRIG_FIXED_ONES = 6'h3f;
	localparam logic [9:0] RESULT_RESET    = 10'h000;

	// conversion timing in states (one state is one clock)
	localparam logic [3:0] TD_SLOW_MIN   = 4'h6;
	localparam logic [3:0] TD_SLOW_MAX   = 4'h9;
	localparam logic [3:0] TD_FAST_MIN   = 4'h4;
	localparam logic [3:0] TD_FAST_MAX   = 4'h5;
	localparam logic [7:0] CONV_MAX_SLOW = 8'h86;
	localparam logic [7:0] CONV_MAX_FAST = 8'h46;
	localparam logic [7:0] SCAN_LEN_SLOW = 8'h80;
	localparam logic [7:0] SCAN_LEN_FAST = 8'h42;
	localparam logic [7:0] SPL_SLOW      = 8'h1f;
	localparam logic [7:0] SPL_FAST      = 8'h0f;
	localparam logic [7:0] TAIL_SLOW     = CONV_MAX_SLOW - {4'h0, TD_SLOW_MAX};
	localparam logic [7:0] TAIL_FAST     = CONV_MAX_FAST - {4'h0, TD_FAST_MAX};
	localparam logic [7:0] TD_SCAN_SLOW  = SCAN_LEN_SLOW - TAIL_SLOW;
	localparam logic [7:0] TD_SCAN_FAST  = SCAN_LEN_FAST - TAIL_FAST;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [3:0] addr;
		logic [7:0] wdata;
	} cpu_req_s;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_CONV = 1'b1
	} conv_state_e;

endpackage

// *** design/adc_conv_timer.sv ***
`timescale 1ns/10ps
`default_nettype none

module adc_conv_timer #(
	parameter int CW = 8
) (
	input  wire logic          clk,     // system clock
	input  wire logic          reset,   // async reset, active high
	input  wire logic          clk_en,  // freezes state when low
	input  wire logic          clear,   // abandon any running conversion
	input  wire logic          start,   // begin a conversion
	input  wire logic [CW-1:0] td,      // delay before sampling
	input  wire logic [CW-1:0] tail,    // states from end of delay to end
	input  wire logic [CW-1:0] spl,     // sampling window length
	output logic               smp,     // sampling window active
	output logic               done     // one-cycle pulse at conversion end
);

	logic          run_reg;
	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] td_reg;
	logic [CW-1:0] len_reg;
	logic [CW-1:0] spl_reg;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			run_reg <= 1'b0;
			cnt_reg <= '0;
			td_reg  <= '0;
			len_reg <= '0;
			spl_reg <= '0;
			smp     <= 1'b0;
			done    <= 1'b0;
		end else if (clk_en) begin
			done <= 1'b0;
			if (clear) begin
				run_reg <= 1'b0;
				smp     <= 1'b0;
				cnt_reg <= '0;
			end else if (start) begin
				run_reg <= 1'b1;
				cnt_reg <= CW'(1);
				td_reg  <= td;
				len_reg <= CW'(td + tail);
				spl_reg <= spl;
				smp     <= 1'b0;
			end else if (run_reg) begin
				cnt_reg <= CW'(cnt_reg + CW'(1));
				smp     <= (cnt_reg >= td_reg) && (cnt_reg < CW'(td_reg + spl_reg));
				if (cnt_reg == CW'(len_reg - CW'(1))) begin
					run_reg <= 1'b0;
					smp     <= 1'b0;
					done    <= 1'b1;
				end
			end
		end
	end

endmodule
`default_nettype wire

// *** bench/adc_cpu_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module adc_cpu_model (
	input  wire logic                 clk,   // system clock
	input  wire logic [7:0]           rdata, // read data from the device
	output var adc_seq_pkg::cpu_req_s cpu    // byte access request
);
	initial cpu = '0;

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		cpu <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge clk);
		cpu <= '0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		cpu <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge clk);
		cpu <= '0;
		#1 d = rdata;
	endtask

	// upper byte first so the latch holds the matching low byte
	task automatic rd_result(input logic [1:0] r, output logic [15:0] d);
		rd({1'b0, r, 1'b0}, d[15:8]);
		rd({1'b0, r, 1'b1}, d[7:0]);
	endtask

	task automatic clear_flag();
		logic [7:0] v;
		rd(adc_seq_pkg::OFF_CTRL_STATUS, v);
		wr(adc_seq_pkg::OFF_CTRL_STATUS, v & 8'h7f);
	endtask

	// new settings land with go dropped, then go is set
	task automatic start(input logic [7:0] v);
		wr(adc_seq_pkg::OFF_CTRL_STATUS, v & 8'hdf);
		wr(adc_seq_pkg::OFF_CTRL_STATUS, v);
	endtask
endmodule

`default_nettype wire

// *** bench/adc_sequencer_control_test.sv ***
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) check(16'(g), 16'(e))

module adc_sequencer_control_test;
	localparam logic [3:0] CS = adc_seq_pkg::OFF_CTRL_STATUS;
	localparam logic [3:0] TR = adc_seq_pkg::OFF_TRIG_CTRL;

	logic                   clk;
	logic                   reset;
	logic                   standby;
	logic                   clk_en;
	logic                   ext_trig_n;
	logic                   timer_match;
	logic                   timer_trig_sel;
	logic [9:0]             conv_result;
	logic [6:0]             tone;
	adc_seq_pkg::cpu_req_s  cpu;
	logic [7:0]             rdata;
	logic                   done_irq;
	logic [2:0]             analog_sel;
	logic                   sample_en;
	logic                   busy;
	int                     num_errors;
	int                     n_tests;

	adc_sequencer_control dut (
		.clk(clk), .reset(reset), .clk_en(clk_en), .standby(standby), .cpu(cpu), .rdata(rdata),
		.done_irq(done_irq), .ext_trig_n(ext_trig_n), .timer_match(timer_match),
		.timer_trig_sel(timer_trig_sel), .conv_result(conv_result), .analog_sel(analog_sel),
		.sample_en(sample_en), .busy(busy)
	);

	adc_cpu_model host (.clk(clk), .rdata(rdata), .cpu(cpu));

	always #20 clk = ~clk;

	// analog core stand-in: code tells which input was converted
	always @(posedge clk) begin
		conv_result <= {analog_sel, tone};
	end

	function automatic logic [15:0] exp_res(input logic [2:0] c);
		return {c, tone, 6'h00};
	endfunction

	task automatic wrap_up();
		$display("errors=%0d checks=%0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// bounded wait on busy (smp=0) or sample_en (smp=1)
	task automatic wait_on(input logic smp, input logic lvl, input int lim, output int n);
		n = 0;
		while ((smp ? sample_en : busy) !== lvl) begin
			@(posedge clk);
			#1;
			n++;
			if (n > lim) begin
				num_errors++;
				$display("[ERR] t=%0t got=%h exp=%h", $time, ~lvl, lvl);
				wrap_up();
			end
		end
	endtask

	task automatic t_reset();
		logic [7:0] v;
		logic [15:0] r;
		host.rd(CS, v);
		`CHK(v, adc_seq_pkg::CTRL_RESET);
		host.rd(TR, v);
		`CHK(v, adc_seq_pkg::TRIG_RESET);
		for (int i = 0; i < 4; i++) begin
			host.rd_result(2'(i), r);
			`CHK(r, 16'h0000);
		end
		host.wr(TR, 8'h00);
		host.rd(TR, v);
		`CHK(v, 8'h7e);
		host.wr(TR, 8'h80);
		host.rd(TR, v);
		`CHK(v, 8'hfe);
		host.wr(TR, 8'h7e);
	endtask

	task automatic t_single(input logic spd, input logic [2:0] ch);
		logic [7:0] v;
		logic [7:0] c;
		logic [15:0] r;
		int n;
		logic [7:0] hi;
		logic [7:0] lo;
		c = {4'b0100, spd, ch};
		hi = spd ? adc_seq_pkg::CONV_MAX_FAST : adc_seq_pkg::CONV_MAX_SLOW;
		lo = spd ? adc_seq_pkg::CONV_MAX_FAST - 8'(adc_seq_pkg::TD_FAST_MAX - adc_seq_pkg::TD_FAST_MIN)
			: adc_seq_pkg::CONV_MAX_SLOW - 8'(adc_seq_pkg::TD_SLOW_MAX - adc_seq_pkg::TD_SLOW_MIN);
		tone = tone + 7'h13;
		host.start(c | 8'h20);
		wait_on(0, 1, 5, n);
		wait_on(0, 0, 200, n);
		`CHK(n <= int'(hi) && n >= int'(lo), 1'b1);
		repeat (2) @(posedge clk);
		#1;
		`CHK(done_irq, 1'b1);
		host.rd(CS, v);
		`CHK(v, c | 8'h80);
		host.rd_result(ch[1:0], r);
		`CHK(r, exp_res(ch));
		host.wr(CS, c | 8'h80);
		host.wr(CS, c);
		host.rd(CS, v);
		`CHK(v, c | 8'h80);
		host.wr(CS, c);
		host.rd(CS, v);
		`CHK(v, c);
		`CHK(done_irq, 1'b0);
	endtask

	task automatic t_scan(input logic spd);
		logic [7:0] v;
		logic [7:0] c;
		logic [15:0] r;
		logic [15:0] keep;
		int n;
		int m;
		v = 8'h00;
		c = {4'b0011, spd, 3'h6};
		tone = tone + 7'h29;
		host.start(c);
		for (int i = 0; i < 300 && v[7] !== 1'b1; i++) begin
			host.rd(CS, v);
		end
		`CHK(v, c | 8'h80);
		`CHK(done_irq, 1'b0);
		for (int i = 0; i < 4; i++) begin
			host.rd_result(2'(i), r);
			`CHK(r, (i < 3) ? exp_res(3'(4 + i)) : 16'h0000);
		end
		wait_on(1, 0, 100, n);
		wait_on(1, 1, 100, n);
		wait_on(1, 0, 100, n);
		`CHK(n, spd ? adc_seq_pkg::SPL_FAST : adc_seq_pkg::SPL_SLOW);
		wait_on(1, 1, 100, m);
		`CHK(n + m, spd ? adc_seq_pkg::SCAN_LEN_FAST : adc_seq_pkg::SCAN_LEN_SLOW);
		host.clear_flag();
		host.wr(CS, c & 8'hdf);
		wait_on(0, 0, 5, n);
		host.rd(CS, v);
		`CHK(v, c & 8'hdf);
		keep = exp_res(3'h4);
		tone = tone + 7'h31;
		c = {4'b0011, spd, 3'h5};
		host.start(c);
		wait_on(1, 1, 20, n);
		`CHK(analog_sel, 3'h4);
		host.wr(CS, c & 8'hdf);
		wait_on(0, 0, 5, n);
		host.rd_result(2'd0, r);
		`CHK(r, keep);
		host.rd(CS, v);
		`CHK(v, c & 8'hdf);
	endtask

	task automatic t_trig();
		logic [15:0] r;
		int n;
		tone = tone + 7'h0b;
		host.wr(CS, 8'h0a);
		@(posedge clk) ext_trig_n <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		`CHK(busy, 1'b0);
		@(posedge clk) ext_trig_n <= 1'b1;
		host.wr(TR, 8'h80);
		@(posedge clk) ext_trig_n <= 1'b0;
		wait_on(0, 1, 5, n);
		wait_on(0, 0, 200, n);
		host.rd_result(2'd2, r);
		`CHK(r, exp_res(3'h2));
		@(posedge clk) ext_trig_n <= 1'b1;
		timer_trig_sel <= 1'b1;
		@(posedge clk) timer_match <= 1'b1;
		@(posedge clk) timer_match <= 1'b0;
		wait_on(0, 1, 5, n);
		wait_on(0, 0, 200, n);
	endtask

	task automatic t_standby();
		logic [7:0] v;
		logic [15:0] r;
		host.wr(CS, 8'h4a);
		// standby is ignored while the clock enable is low
		@(posedge clk) clk_en <= 1'b0;
		@(posedge clk) standby <= 1'b1;
		@(posedge clk) standby <= 1'b0;
		@(posedge clk) clk_en <= 1'b1;
		host.rd(CS, v);
		`CHK(v, 8'hca);
		@(posedge clk) standby <= 1'b1;
		@(posedge clk) standby <= 1'b0;
		host.rd(TR, v);
		`CHK(v, adc_seq_pkg::TRIG_RESET);
		host.rd(CS, v);
		`CHK(v, adc_seq_pkg::CTRL_RESET);
		host.rd_result(2'd2, r);
		`CHK(r, 16'h0000);
		`CHK(done_irq, 1'b0);
	endtask

	initial begin
		clk = 1'b0;
		reset = 1'b1;
		standby = 1'b0;
		clk_en = 1'b1;
		ext_trig_n = 1'b1;
		timer_match = 1'b0;
		timer_trig_sel = 1'b0;
		conv_result = 10'h000;
		tone = 7'h2a;
		num_errors = 0;
		n_tests = 0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_single(1'b0, 3'h1);
		t_single(1'b1, 3'h6);
		t_scan(1'b1);
		t_scan(1'b0);
		t_trig();
		t_standby();
		wrap_up();
	end
endmodule

`default_nettype wire
